/* File: hw/dp_pkg.sv */
package dp_pkg;

	// ****************************************
	// Widths and fixed values
	// ****************************************
	localparam int          WIPER_W         = 7;
	localparam int          TAP_COUNT       = 128;
	localparam logic [4:0]  ID_PREFIX       = 5'h0a;
	localparam logic [7:0]  WIPER_REG_ADDR  = 8'h00;
	localparam logic [6:0]  WIPER_RESET     = 7'h20;
	localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
	localparam int          STRAP_LSB       = 1;
	localparam int          PREFIX_LSB      = 3;
	localparam int          RW_BIT          = 0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_ID       = 4'h1,
		ST_ID_ACK   = 4'h2,
		ST_REG      = 4'h3,
		ST_REG_ACK  = 4'h4,
		ST_DATA     = 4'h5,
		ST_DATA_ACK = 4'h6,
		ST_TX       = 4'h7,
		ST_TX_ACK   = 4'h8,
		ST_IGNORE   = 4'h9
	} dp_state_e;

	// Bus events as seen in the system clock domain
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic bit_val;
	} dp_ev_s;

	// Pins after synchronisation
	typedef struct packed {
		logic       tgl;
		logic       scl;
		logic       sda;
		logic [1:0] strap;
	} dp_pins_s;

endpackage

/* File: hw/dp_sync.sv */
`timescale 1ns/1ns
module dp_sync #(
	parameter int W = 5
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage1_reg;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end

endmodule // dp_sync

/* File: hw/dp_wiper_slave.sv */
`timescale 1ns/1ns
module dp_wiper_slave (
	input  wire logic                             mclk_in,
	input  wire logic                             rst_in,
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out,
	output logic                                  sda_oe_out,
	input  wire logic [1:0]                       addr_strap_pins_in,
	output logic      [dp_pkg::WIPER_W-1:0]       wiper_position_out,
	output logic      [dp_pkg::TAP_COUNT-1:0]     tap_sel_out
);

	// ****************************************
	// Link clock domain: bit capture on SCL
	// ****************************************
	logic rise_tgl_reg;
	logic rise_bit_reg;

	// Each rising edge samples SDA and flips a toggle for the other domain
	always_ff @(posedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			rise_tgl_reg <= 1'b0;
			rise_bit_reg <= 1'b0;
		end else begin
			rise_tgl_reg <= ~rise_tgl_reg;
			rise_bit_reg <= sda_in;
		end
	end

	// ****************************************
	// Crossing into the system clock
	// ****************************************
	dp_pkg::dp_pins_s pins_raw;
	dp_pkg::dp_pins_s pins_s;

	assign pins_raw = '{tgl: rise_tgl_reg, scl: scl_in, sda: sda_in,
		strap: addr_strap_pins_in};

	dp_sync #(
		.W ($bits(dp_pkg::dp_pins_s))
	) u_sync (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	logic tgl_prev_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	dp_pkg::dp_ev_s ev;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			// Same value as the synchroniser's reset, so release shows no false edge
			tgl_prev_reg <= 1'b0;
			scl_prev_reg <= 1'b0;
			sda_prev_reg <= 1'b0;
		end else begin
			tgl_prev_reg <= pins_s.tgl;
			scl_prev_reg <= pins_s.scl;
			sda_prev_reg <= pins_s.sda;
		end
	end

	// Captured bit is stable for a whole SCL period once the toggle is seen
	always_comb begin
		ev.rise    = pins_s.tgl ^ tgl_prev_reg;
		ev.bit_val = rise_bit_reg;
		ev.fall    = scl_prev_reg & ~pins_s.scl;
		ev.start   = pins_s.scl & scl_prev_reg & sda_prev_reg & ~pins_s.sda;
		ev.stop    = pins_s.scl & scl_prev_reg & ~sda_prev_reg & pins_s.sda;
	end

	// ****************************************
	// Protocol engine
	// ****************************************
	dp_pkg::dp_state_e state_reg;
	logic [3:0]       cnt_reg;
	logic [7:0]       rx_reg;
	logic [7:0]       tx_reg;
	logic [7:0]       reg_addr_reg;
	logic             rw_reg;
	logic             oe_reg;
	logic [dp_pkg::WIPER_W-1:0] wiper_reg;
	logic             byte_done;
	logic             id_match;
	logic             receiving;

	function automatic logic id_ok(input logic [7:0] id, input logic [1:0] strap);
		id_ok = (id[7:dp_pkg::PREFIX_LSB] == dp_pkg::ID_PREFIX) &&
			(id[dp_pkg::PREFIX_LSB-1:dp_pkg::STRAP_LSB] == strap);
	endfunction

	// Only seven bits exist, so a write can never land past either end
	function automatic logic [dp_pkg::WIPER_W-1:0] clamp_wiper(input logic [7:0] d);
		clamp_wiper = d[dp_pkg::WIPER_W-1:0];
	endfunction

	assign byte_done = (cnt_reg == dp_pkg::BITS_PER_BYTE);
	assign id_match  = id_ok(rx_reg, pins_s.strap);
	assign receiving = (state_reg == dp_pkg::ST_ID) || (state_reg == dp_pkg::ST_REG) ||
		(state_reg == dp_pkg::ST_DATA);

	// Bit counter and receive shifter advance on rising edges
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= 4'h0;
			rx_reg  <= 8'h00;
		end else if (ev.start || (ev.fall && byte_done)) begin
			cnt_reg <= 4'h0;
		end else if (ev.rise && !byte_done && (receiving || state_reg == dp_pkg::ST_TX)) begin
			cnt_reg <= cnt_reg + 4'h1;
			rx_reg  <= {rx_reg[6:0], ev.bit_val};
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg    <= dp_pkg::ST_IDLE;
			oe_reg       <= 1'b0;
			rw_reg       <= 1'b0;
			reg_addr_reg <= 8'h00;
			tx_reg       <= 8'h00;
		end else if (ev.start) begin
			state_reg <= dp_pkg::ST_ID;
			oe_reg    <= 1'b0;
		end else if (ev.stop) begin
			state_reg <= dp_pkg::ST_IDLE;
			oe_reg    <= 1'b0;
		end else if (ev.fall) begin
			case (state_reg)
			dp_pkg::ST_ID: begin
				if (byte_done && id_match) begin
					state_reg <= dp_pkg::ST_ID_ACK;
					oe_reg    <= 1'b1;
					rw_reg    <= rx_reg[dp_pkg::RW_BIT];
				end else if (byte_done) begin
					state_reg <= dp_pkg::ST_IGNORE;
				end
			end
			dp_pkg::ST_ID_ACK: begin
				if (rw_reg) begin
					state_reg <= dp_pkg::ST_TX;
					oe_reg    <= ~1'b0;
					tx_reg    <= {wiper_reg, 1'b0};
				end else begin
					state_reg <= dp_pkg::ST_REG;
					oe_reg    <= 1'b0;
				end
			end
			dp_pkg::ST_REG: begin
				if (byte_done) begin
					state_reg    <= dp_pkg::ST_REG_ACK;
					oe_reg       <= 1'b1;
					reg_addr_reg <= rx_reg;
				end
			end
			dp_pkg::ST_REG_ACK: begin
				state_reg <= dp_pkg::ST_DATA;
				oe_reg    <= 1'b0;
			end
			dp_pkg::ST_DATA: begin
				if (byte_done) begin
					state_reg <= dp_pkg::ST_DATA_ACK;
					oe_reg    <= 1'b1;
				end
			end
			dp_pkg::ST_DATA_ACK: begin
				state_reg <= dp_pkg::ST_IGNORE;
				oe_reg    <= 1'b0;
			end
			dp_pkg::ST_TX: begin
				if (byte_done) begin
					state_reg <= dp_pkg::ST_TX_ACK;
					oe_reg    <= 1'b0;
				end else begin
					oe_reg <= ~tx_reg[7];
					tx_reg <= {tx_reg[6:0], 1'b0};
				end
			end
			dp_pkg::ST_TX_ACK: begin
				// Only one byte exists, so the controller's answer ends the read
				state_reg <= dp_pkg::ST_IGNORE;
				oe_reg    <= 1'b0;
			end
			default: begin
				oe_reg <= 1'b0;
			end
			endcase
		end
	end

	// ****************************************
	// Wiper register and tap decode
	// ****************************************
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wiper_reg <= dp_pkg::WIPER_RESET;
		end else if (ev.fall && state_reg == dp_pkg::ST_DATA && byte_done &&
			reg_addr_reg == dp_pkg::WIPER_REG_ADDR) begin
			wiper_reg <= clamp_wiper(rx_reg);
		end
	end

	// Tap i sits i steps above the low terminal
	genvar gi;
	generate
		for (gi = 0; gi < dp_pkg::TAP_COUNT; gi++) begin : g_tap
			localparam logic [dp_pkg::WIPER_W-1:0] TAP_CODE = (dp_pkg::WIPER_W)'(gi);
			always_ff @(posedge mclk_in or posedge rst_in) begin
				if (rst_in) begin
					tap_sel_out[gi] <= (gi == int'(dp_pkg::WIPER_RESET));
				end else begin
					tap_sel_out[gi] <= (wiper_reg == TAP_CODE);
				end
			end
		end
	endgenerate

	assign wiper_position_out = wiper_reg;
	assign sda_out            = 1'b0;
	assign sda_oe_out         = oe_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// Every change of the pull-down follows an SCL fall, a start or a stop
	a_sda_change_edge: assert property ($changed(oe_reg) |->
		$past(ev.fall) || $past(ev.start) || $past(ev.stop))
		else $error("SDA drive changed outside an SCL falling edge");
	// The pin is only ever pulled low, and only in an ack or read data slot
	a_sda_low_only: assert property (sda_out == 1'b0 && (!sda_oe_out ||
		state_reg inside {dp_pkg::ST_ID_ACK, dp_pkg::ST_REG_ACK, dp_pkg::ST_DATA_ACK,
		dp_pkg::ST_TX}))
		else $error("SDA pulled low outside an ack or read slot");
	a_id_reject: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_ID && byte_done && !id_match |=>
		state_reg == dp_pkg::ST_IGNORE && !sda_oe_out)
		else $error("Foreign address answered");
	a_id_accept: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_ID && byte_done && id_match |=>
		state_reg == dp_pkg::ST_ID_ACK && sda_oe_out)
		else $error("Own address not acknowledged");
	a_rx_count: assert property (ev.rise && !ev.start && !ev.fall && receiving &&
		!byte_done |=> cnt_reg == $past(cnt_reg) + 4'h1 && rx_reg[0] == $past(ev.bit_val))
		else $error("Received bit not shifted in");
	a_reg_ack: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_REG && byte_done |=>
		state_reg == dp_pkg::ST_REG_ACK && sda_oe_out)
		else $error("Register address byte not acknowledged");
	a_wiper_write: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_DATA && byte_done && reg_addr_reg == dp_pkg::WIPER_REG_ADDR
		|=> wiper_reg == $past(rx_reg[6:0]))
		else $error("Wiper write lost");
	a_ack_release: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_DATA_ACK |=> state_reg == dp_pkg::ST_IGNORE && !sda_oe_out)
		else $error("Data byte ack not released");
	a_wiper_other: assert property (!(ev.fall && state_reg == dp_pkg::ST_DATA &&
		byte_done && reg_addr_reg == dp_pkg::WIPER_REG_ADDR) |=> $stable(wiper_reg))
		else $error("Wiper changed without a write to address 0");
	a_tx_first: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_ID_ACK && rw_reg |=> sda_oe_out && tx_reg[7:1] == wiper_reg)
		else $error("Read did not start with a zero MSB");
	a_tx_bit: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_TX && !byte_done |=> sda_oe_out == !$past(tx_reg[7]))
		else $error("Wrong read bit on SDA");
	a_tx_end: assert property (ev.fall && !ev.start && !ev.stop &&
		state_reg == dp_pkg::ST_TX && byte_done |=>
		state_reg == dp_pkg::ST_TX_ACK && !sda_oe_out)
		else $error("Read data ran past eight bits");
	a_tap_follow: assert property (##1 tap_sel_out ==
		(dp_pkg::TAP_COUNT'(1) << $past(wiper_reg)))
		else $error("Tap select does not follow the wiper");
	a_stop_idle: assert property (ev.stop && !ev.start |=>
		state_reg == dp_pkg::ST_IDLE && !sda_oe_out)
		else $error("Stop did not release the bus");

	// Scenarios the bench is expected to reach
	c_write: cover property (state_reg == dp_pkg::ST_DATA_ACK && ev.fall);
	c_read: cover property (state_reg == dp_pkg::ST_TX_ACK && ev.fall);
	c_reject: cover property (state_reg == dp_pkg::ST_IGNORE && ev.stop);
	c_top: cover property (wiper_reg == 7'h7f);
	c_other_addr: cover property (state_reg == dp_pkg::ST_DATA_ACK &&
		reg_addr_reg != dp_pkg::WIPER_REG_ADDR);

endmodule // dp_wiper_slave

/* File: test/dp_ctl_model.sv */
`timescale 1ns/1ns
module dp_ctl_model (
	input  wire logic lclk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_oe_out
);
	// SCL rests high between frames; a bit spans 20 link ticks, so each
	// SCL phase lasts about 640 ns, slow enough for the synchronisers
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge lclk_in);
	endtask
	// Also serves as a repeated start from SCL low
	task automatic start_cond();
		sda_oe_out <= 1'b0;
		tk(5);
		scl_out <= 1'b1;
		tk(10);
		sda_oe_out <= 1'b1;
		tk(10);
		scl_out <= 1'b0;
		tk(5);
	endtask
	// Long idle after the stop keeps the bus-free time
	task automatic stop_cond();
		sda_oe_out <= 1'b1;
		tk(5);
		scl_out <= 1'b1;
		tk(10);
		sda_oe_out <= 1'b0;
		tk(25);
	endtask
	// Data moves only while SCL is low and is sampled mid-high
	task automatic one_bit(input logic b, output logic s);
		sda_oe_out <= ~b;
		tk(5);
		scl_out <= 1'b1;
		tk(5);
		s = sda_in;
		tk(5);
		scl_out <= 1'b0;
		tk(5);
	endtask
	// MSB first; the ninth bit is our ack or nack, or a released line
	task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
		output logic s9);
		for (int i = 7; i >= 0; i--) begin
			one_bit(d[i], q[i]);
		end
		one_bit(b9, s9);
	endtask
endmodule // dp_ctl_model

/* File: test/dp_wiper_slave_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("mismatch %s exp %h got %h", nm, e, g); \
	end \
end
module dp_wiper_slave_tb;
	logic         mclk_in;
	logic         lclk;
	logic         rst_in;
	logic [1:0]   addr_strap_pins;
	logic         scl;
	logic         m_oe;
	logic         sda_out;
	logic         sda_oe;
	wire          sda_line;
	logic [6:0]   wiper;
	logic [127:0] tap_sel;
	int           fail_count;
	int           total_checks;

	// Open-drain wire with a pull-up
	assign sda_line = ~(sda_oe | m_oe);

	dp_wiper_slave u_dut (
		.mclk_in            (mclk_in),
		.rst_in             (rst_in),
		.scl_in             (scl),
		.sda_in             (sda_line),
		.sda_out            (sda_out),
		.sda_oe_out         (sda_oe),
		.addr_strap_pins_in (addr_strap_pins),
		.wiper_position_out (wiper),
		.tap_sel_out        (tap_sel)
	);
	dp_ctl_model u_ctl (
		.lclk_in    (lclk),
		.sda_in     (sda_line),
		.scl_out    (scl),
		.sda_oe_out (m_oe)
	);

	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// Link tick clock, phase unrelated to mclk
	initial begin
		lclk = 1'b0;
		#3;
		forever #32 lclk = ~lclk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Write transaction; acks[2] is the id byte
	task automatic wr_txn(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
		output logic [2:0] acks);
		logic [7:0] q;
		logic       s;
		u_ctl.start_cond();
		u_ctl.xfer({dev, 1'b0}, 1'b1, q, s);
		acks[2] = ~s;
		u_ctl.xfer(ra, 1'b1, q, s);
		acks[1] = ~s;
		u_ctl.xfer(d, 1'b1, q, s);
		acks[0] = ~s;
		u_ctl.stop_cond();
	endtask
	// Read transaction; the controller ends with a nack
	task automatic rd_txn(input logic [6:0] dev, output logic ack, output logic [7:0] q);
		logic [7:0] dummy;
		logic       s;
		u_ctl.start_cond();
		u_ctl.xfer({dev, 1'b1}, 1'b1, dummy, s);
		ack = ~s;
		u_ctl.xfer(8'hff, 1'b1, q, s);
		u_ctl.stop_cond();
	endtask

	task automatic t_reset();
		`CHK("wiper", 7'h20, wiper)
		`CHK("tap", 128'h1 << 32, tap_sel)
		`CHK("sda_oe", 1'b0, sda_oe)
		$display("test reset done");
	endtask
	// Boundaries and the ignored top bit, each read back
	task automatic t_wr_rd();
		logic [7:0] vals [4] = '{8'h00, 8'h7f, 8'hff, 8'h41};
		logic [2:0] acks;
		logic [7:0] q;
		logic       ack;
		for (int i = 0; i < 4; i++) begin
			wr_txn({5'h0a, addr_strap_pins}, 8'h00, vals[i], acks);
			`CHK("wr acks", 3'h7, acks)
			`CHK("wiper", vals[i][6:0], wiper)
			`CHK("tap", 128'h1 << vals[i][6:0], tap_sel)
			rd_txn({5'h0a, addr_strap_pins}, ack, q);
			`CHK("rd ack", 1'b1, ack)
			`CHK("rd data", {1'b0, vals[i][6:0]}, q)
		end
		`CHK("sda_out", 1'b0, sda_out)
		$display("test write read done");
	endtask
	task automatic t_other_addr();
		logic [2:0] acks;
		wr_txn({5'h0a, addr_strap_pins}, 8'h01, 8'h11, acks);
		`CHK("acks", 3'h7, acks)
		`CHK("wiper", 7'h41, wiper)
		$display("test other address done");
	endtask
	// Reset in mid-run must reload the power-up value with the bus idle
	task automatic t_mid_reset();
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (20) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
		t_reset();
	endtask
	// Every strap setting; foreign ids must get no ack and change nothing
	task automatic t_straps();
		logic [2:0] acks;
		for (int s = 0; s < 4; s++) begin
			@(posedge mclk_in);
			addr_strap_pins <= 2'(s);
			repeat (100) @(posedge mclk_in);
			wr_txn({5'h0a, 2'(s)}, 8'h00, {6'h02, 2'(s)}, acks);
			`CHK("own acks", 3'h7, acks)
			wr_txn({5'h0a, 2'(s ^ 1)}, 8'h00, 8'h70, acks);
			`CHK("other id ack", 1'b0, acks[2])
			wr_txn({5'h0b, 2'(s)}, 8'h00, 8'h70, acks);
			`CHK("prefix ack", 1'b0, acks[2])
			`CHK("wiper", {5'h02, 2'(s)}, wiper)
		end
		$display("test straps done");
	endtask

	initial begin
		repeat (95000) @(posedge mclk_in);
		$display("timeout");
		fail_count++;
		end_of_test();
	end
	initial begin
		rst_in = 1'b1;
		addr_strap_pins = 2'h2;
		fail_count = 0;
		total_checks = 0;
		repeat (20) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
		t_reset();
		t_wr_rd();
		t_other_addr();
		t_mid_reset();
		t_straps();
		end_of_test();
	end
endmodule // dp_wiper_slave_tb
